// ---- sml_pkg.sv ----
// sml_pkg: register map, field positions, reset values and limits of the signal and lock monitor
// assumes: included first in compile order, used only as sml_pkg::name
`default_nettype none
package sml_pkg;
   // register offsets
   localparam logic [7:0] ADDR_STATUS = 8'h06;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_CTRL_B = 8'h09;
   localparam logic [7:0] ADDR_CTRL_C = 8'h0A;
   localparam logic [7:0] ADDR_REF_CFG = 8'h0F;
   localparam logic [7:0] ADDR_SLICE = 8'h15;
   localparam logic [7:0] ADDR_EQ = 8'h16;
   localparam logic [7:0] ADDR_LD_DATA = 8'h36;
   localparam logic [7:0] ADDR_LD_CTRL = 8'h74;
   // field positions
   localparam int STAT_ABSENT_BIT = 0;
   localparam int STAT_UNLOCK_BIT = 1;
   localparam int STAT_STICKY_BIT = 2;
   localparam int MODE_STICKY_CLR_BIT = 2;
   localparam int MODE_SEL_LSB = 4;
   localparam int CTRLB_PDN_BIT = 3;
   localparam int CTRLB_PIN_SEL_BIT = 4;
   localparam int CONTROL_REGISTER_C_REF_PDN_BIT = 2;
   localparam int CONTROL_REGISTER_C_FAST_ACQ_BIT = 0;
   localparam int REFCFG_RANGE_LSB = 4;
   localparam int EQ_ADAPT_BIT = 6;
   localparam int EQ_TERM_FLOAT_BIT = 7;
   localparam int LDC_STROBE_BIT = 4;
   // reset values
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_CTRL_C = 8'h05;
   localparam logic [7:0] RST_REF_CFG = 8'h00;
   localparam logic [7:0] RST_SLICE = 8'h00;
   localparam logic [7:0] RST_EQ = 8'h40;
   localparam logic [7:0] RST_LD_DATA = 8'h00;
   localparam logic [7:0] RST_LD_CTRL = 8'h00;
   // field values and limits
   localparam logic [2:0] MODE_REF_ASSISTED = 3'h3;
   localparam logic [2:0] TARGET_THRESHOLD = 3'h1;
   localparam logic [2:0] TARGET_MEASURE = 3'h7;
   localparam logic [7:0] THR_MAX_MV = 8'h80;
   localparam logic [7:0] THR_FINE_LIMIT_MV = 8'h3F;
   localparam int LOCK_PPM = 250;
   localparam int UNLOCK_PPM = 1000;
   localparam int PPM_SCALE = 1000000;
   localparam int LOCK_DIV = PPM_SCALE / LOCK_PPM;
   localparam int UNLOCK_DIV = PPM_SCALE / UNLOCK_PPM;
   localparam int MEAS_INTERVAL_CYCLES = 65536;
   typedef enum logic [2:0] {
      SML_IDLE = 3'b001,
      SML_ARMED_LOW = 3'b010,
      SML_ARMED_HIGH = 3'b100
   } sml_meas_t;
endpackage
`default_nettype wire

// ---- sml_freq_cmp.sv ----
// sml_freq_cmp: counts oscillator and target edges over a fixed interval and grades the frequency error
// assumes: tick inputs are one-cycle pulses synchronous to clk, at most one per cycle each
`default_nettype none
module sml_freq_cmp #(
   parameter int CW = 24,
   parameter int INTERVAL = sml_pkg::MEAS_INTERVAL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic osc_tick,
   input wire logic tgt_tick,
   output logic eval,
   output logic within_lock,
   output logic beyond_unlock
);
   localparam int PW = CW + 20;
   logic [31:0] tick_cnt;
   logic [CW-1:0] osc_cnt;
   logic [CW-1:0] tgt_cnt;
   wire interval_end = (tick_cnt == 32'(INTERVAL - 1));
   wire [CW-1:0] diff = (osc_cnt > tgt_cnt) ? osc_cnt - tgt_cnt : tgt_cnt - osc_cnt;
   wire [PW-1:0] diff_lock = PW'(diff) * PW'(sml_pkg::LOCK_DIV);
   wire [PW-1:0] diff_unlock = PW'(diff) * PW'(sml_pkg::UNLOCK_DIV);
   wire [PW-1:0] tgt_wide = PW'(tgt_cnt);
   wire tgt_none = (tgt_cnt == '0);

   ////////////////////////////////////////////////////////////////////////////////
   // interval timer and edge counters
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 32'h0;
         osc_cnt <= '0;
         tgt_cnt <= '0;
      end else if (clear || interval_end) begin
         tick_cnt <= 32'h0;
         osc_cnt <= '0;
         tgt_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         osc_cnt <= osc_cnt + CW'(osc_tick);
         tgt_cnt <= tgt_cnt + CW'(tgt_tick);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ppm grading, once per interval
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eval <= 1'b0;
         within_lock <= 1'b0;
         beyond_unlock <= 1'b0;
      end else begin
         eval <= interval_end && !clear; // R19
         if (interval_end) begin
            within_lock <= !tgt_none && (diff_lock <= tgt_wide); // R19
            beyond_unlock <= tgt_none || (diff_unlock > tgt_wide); // R19
         end
      end
   end
endmodule
`default_nettype wire

// ---- sml_monitor.sv ----
// sml_monitor: signal-level detector control, equalizer and termination bits, lock indication
// assumes: register port is driven by the serial-bus slave in front of it; level and tick inputs are synchronous
// Operation
// R1 - signal absent sets below threshold, clears only at twice the threshold
// R2 - level detection uses absolute level, slice setting never enters it
// R3 - detector enabled after reset, powered down by control bit D3
// R4 - threshold up to 128 mV loaded from data register on strobe with target 1
// R5 - host writes control 0x21, data, 0x31, then 0x21 to load threshold
// R6 - thresholds 64 to 128 lose bit D0, giving 2 mV steps
// R7 - control 0x7, 0x17, 0x7 loads measured peak-to-peak millivolts into data
// R8 - data changes by measurement only on low-high-low strobe with target 7
// R9 - equalizer adaptive after reset, manual code taken from equalizer register
// R10 - equalizer bit D7 floats terminations, zero ties them to core supply
// R11 - without reference, unlocked clears within 250 ppm and enables digital phase loop
// R12 - above 1000 ppm unlocked reasserts and acquisition restarts
// R13 - recovery mode field value 3 selects reference-assisted acquisition
// R14 - host sets reference range and divide ratio in reference config register
// R15 - host clears reference buffer powerdown bit and keeps fast-acquire bit set
// R16 - reference mode compares divided oscillator against divided reference, same limits
// R17 - sticky loss-of-lock bit set on any loss, cleared by writing 1 then 0; code leaves it clear on the unlock forced by a mode change
// R18 - pin select bit chooses sticky bit or live lock state for unlocked pin
// R19 - frequency error from edge counts over fixed interval, graded once per interval
`default_nettype none
module sml_monitor #(
   parameter int CW = 24,
   parameter int INTERVAL = sml_pkg::MEAS_INTERVAL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] level_mv,
   input wire logic osc_tick,
   input wire logic data_tick,
   input wire logic ref_tick,
   output logic signal_absent_flag,
   output logic unlocked_indicator,
   output logic digital_loop_enable,
   output logic acquire_restart,
   output logic level_detector_powerdown,
   output logic [7:0] loss_threshold_mv,
   output logic eq_adaptive,
   output logic [5:0] eq_manual_code,
   output logic term_float,
   output logic [2:0] recovery_mode_select,
   output logic reference_assisted_acquisition,
   output logic [1:0] reference_range_select,
   output logic [3:0] data_reference_divide,
   output logic reference_buffer_powerdown,
   output logic fast_acquire,
   output logic [7:0] slice_setting
);
   logic [7:0] mode_reg;
   logic [7:0] ctrl_b;
   logic [7:0] control_register_c;
   logic [7:0] ref_lock_ratio_config;
   logic [7:0] equalizer_setting;
   logic [7:0] level_detector_data;
   logic [7:0] level_detector_indirect_control;
   logic sticky_lost;
   logic live_unlocked;
   logic prev_ref_mode;
   sml_pkg::sml_meas_t meas_state;
   sml_pkg::sml_meas_t next_meas_state;

   // threshold clamp and coarse-range rounding
   function automatic logic [7:0] sml_thr_round(input logic [7:0] mv);
      logic [7:0] c;
      c = (mv > sml_pkg::THR_MAX_MV) ? sml_pkg::THR_MAX_MV : mv;
      if (c > sml_pkg::THR_FINE_LIMIT_MV) begin
         c[0] = 1'b0;
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // write decode
   wire wr_mode = reg_wr && (reg_addr == sml_pkg::ADDR_MODE);
   wire wr_ctrl_b = reg_wr && (reg_addr == sml_pkg::ADDR_CTRL_B);
   wire wr_ctrl_c = reg_wr && (reg_addr == sml_pkg::ADDR_CTRL_C);
   wire wr_ref_cfg = reg_wr && (reg_addr == sml_pkg::ADDR_REF_CFG);
   wire wr_slice = reg_wr && (reg_addr == sml_pkg::ADDR_SLICE);
   wire wr_eq = reg_wr && (reg_addr == sml_pkg::ADDR_EQ);
   wire wr_ld_data = reg_wr && (reg_addr == sml_pkg::ADDR_LD_DATA);
   wire wr_ld_ctrl = reg_wr && (reg_addr == sml_pkg::ADDR_LD_CTRL);

   wire old_strobe = level_detector_indirect_control[sml_pkg::LDC_STROBE_BIT];
   wire new_strobe = reg_wdata[sml_pkg::LDC_STROBE_BIT];
   wire [2:0] old_target = level_detector_indirect_control[2:0];
   wire [2:0] new_target = reg_wdata[2:0];
   wire strobe_fall = wr_ld_ctrl && old_strobe && !new_strobe;
   wire load_threshold = strobe_fall && (old_target == sml_pkg::TARGET_THRESHOLD)
      && (new_target == sml_pkg::TARGET_THRESHOLD); // R4 R5
   wire load_measure = wr_ld_ctrl && (meas_state == sml_pkg::SML_ARMED_HIGH)
      && !new_strobe && (new_target == sml_pkg::TARGET_MEASURE); // R7 R8

   ////////////////////////////////////////////////////////////////////////////////
   // single-shot measurement sequencer: strobe low, high, low with target 7
   always_comb begin
      next_meas_state = meas_state;
      if (wr_ld_ctrl) begin
         if (new_target != sml_pkg::TARGET_MEASURE) begin
            next_meas_state = sml_pkg::SML_IDLE; // R8
         end else begin
            case (meas_state)
               sml_pkg::SML_IDLE: begin
                  if (!new_strobe) next_meas_state = sml_pkg::SML_ARMED_LOW;
               end
               sml_pkg::SML_ARMED_LOW: begin
                  if (new_strobe) next_meas_state = sml_pkg::SML_ARMED_HIGH;
               end
               sml_pkg::SML_ARMED_HIGH: begin
                  if (!new_strobe) next_meas_state = sml_pkg::SML_ARMED_LOW;
               end
               default: next_meas_state = sml_pkg::SML_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= sml_pkg::RST_MODE;
         ctrl_b <= sml_pkg::RST_CTRL_B; // R3
         control_register_c <= sml_pkg::RST_CTRL_C;
         ref_lock_ratio_config <= sml_pkg::RST_REF_CFG;
         slice_setting <= sml_pkg::RST_SLICE;
         equalizer_setting <= sml_pkg::RST_EQ; // R9
         level_detector_indirect_control <= sml_pkg::RST_LD_CTRL;
         meas_state <= sml_pkg::SML_IDLE;
      end else begin
         if (wr_mode) mode_reg <= reg_wdata; // R13
         if (wr_ctrl_b) ctrl_b <= reg_wdata;
         if (wr_ctrl_c) control_register_c <= reg_wdata; // R15
         if (wr_ref_cfg) ref_lock_ratio_config <= reg_wdata; // R14
         if (wr_slice) slice_setting <= reg_wdata;
         if (wr_eq) equalizer_setting <= reg_wdata; // R9
         if (wr_ld_ctrl) level_detector_indirect_control <= reg_wdata;
         meas_state <= next_meas_state;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_detector_data <= sml_pkg::RST_LD_DATA;
         loss_threshold_mv <= sml_pkg::RST_LD_DATA;
      end else begin
         if (load_measure) begin
            level_detector_data <= level_mv; // R7 R8
         end else if (wr_ld_data) begin
            level_detector_data <= reg_wdata;
         end
         if (load_threshold) loss_threshold_mv <= sml_thr_round(level_detector_data); // R4 R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // signal-absent detector with 2x hysteresis on absolute level
   wire [8:0] release_level = {loss_threshold_mv, 1'b0};
   wire level_low = ({1'b0, level_mv} < {1'b0, loss_threshold_mv}); // R2
   wire level_good = ({1'b0, level_mv} >= release_level);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         signal_absent_flag <= 1'b0;
      end else if (!level_detector_powerdown) begin
         if (level_low) begin
            signal_absent_flag <= 1'b1; // R1
         end else if (level_good) begin
            signal_absent_flag <= 1'b0; // R1
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // lock detector
   wire ref_mode = (mode_reg[sml_pkg::MODE_SEL_LSB +: 3] == sml_pkg::MODE_REF_ASSISTED); // R13
   wire eval;
   wire within_lock;
   wire beyond_unlock;
   wire tgt_tick = ref_mode ? ref_tick : data_tick; // R16
   wire lose_lock = eval && !live_unlocked && beyond_unlock;
   wire clear_req = wr_mode && mode_reg[sml_pkg::MODE_STICKY_CLR_BIT]
      && !reg_wdata[sml_pkg::MODE_STICKY_CLR_BIT];

   sml_freq_cmp #(
      .CW(CW),
      .INTERVAL(INTERVAL)
   ) u_cmp (
      .clk(clk),
      .rst(rst),
      .clear(ref_mode != prev_ref_mode),
      .osc_tick(osc_tick),
      .tgt_tick(tgt_tick),
      .eval(eval),
      .within_lock(within_lock),
      .beyond_unlock(beyond_unlock)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         live_unlocked <= 1'b1;
         sticky_lost <= 1'b0;
         acquire_restart <= 1'b0;
         prev_ref_mode <= 1'b0;
      end else begin
         prev_ref_mode <= ref_mode;
         acquire_restart <= lose_lock || (ref_mode != prev_ref_mode); // R12 R16
         if (eval && live_unlocked && within_lock) begin
            live_unlocked <= 1'b0; // R11 R16
         end else if (lose_lock || (ref_mode != prev_ref_mode)) begin
            live_unlocked <= 1'b1; // R12 R16
         end
         if (lose_lock) begin
            sticky_lost <= 1'b1; // R17
         end else if (clear_req) begin
            sticky_lost <= 1'b0; // R17
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux, registered
   wire [7:0] status_val = {5'h00, sticky_lost, live_unlocked, signal_absent_flag};
   wire [7:0] rd_mux = (reg_addr == sml_pkg::ADDR_STATUS) ? status_val
      : (reg_addr == sml_pkg::ADDR_MODE) ? mode_reg
      : (reg_addr == sml_pkg::ADDR_CTRL_B) ? ctrl_b
      : (reg_addr == sml_pkg::ADDR_CTRL_C) ? control_register_c
      : (reg_addr == sml_pkg::ADDR_REF_CFG) ? ref_lock_ratio_config
      : (reg_addr == sml_pkg::ADDR_SLICE) ? slice_setting
      : (reg_addr == sml_pkg::ADDR_EQ) ? equalizer_setting
      : (reg_addr == sml_pkg::ADDR_LD_DATA) ? level_detector_data
      : (reg_addr == sml_pkg::ADDR_LD_CTRL) ? level_detector_indirect_control
      : 8'h00;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // configuration outputs
   assign unlocked_indicator = ctrl_b[sml_pkg::CTRLB_PIN_SEL_BIT] ? sticky_lost : live_unlocked; // R18
   assign digital_loop_enable = !live_unlocked; // R11
   assign level_detector_powerdown = ctrl_b[sml_pkg::CTRLB_PDN_BIT]; // R3
   assign eq_adaptive = equalizer_setting[sml_pkg::EQ_ADAPT_BIT]; // R9
   assign eq_manual_code = equalizer_setting[5:0];
   assign term_float = equalizer_setting[sml_pkg::EQ_TERM_FLOAT_BIT]; // R10
   assign recovery_mode_select = mode_reg[sml_pkg::MODE_SEL_LSB +: 3];
   assign reference_assisted_acquisition = ref_mode;
   assign reference_range_select = ref_lock_ratio_config[sml_pkg::REFCFG_RANGE_LSB +: 2];
   assign data_reference_divide = ref_lock_ratio_config[3:0];
   assign reference_buffer_powerdown = control_register_c[sml_pkg::CONTROL_REGISTER_C_REF_PDN_BIT];
   assign fast_acquire = control_register_c[sml_pkg::CONTROL_REGISTER_C_FAST_ACQ_BIT];
endmodule
`default_nettype wire

// ---- sml_monitor_assertions.sv ----
// sml_monitor_assertions: port-level checks of sml_monitor
// assumes: bound into sml_monitor; one clock clk, async reset rst
`default_nettype none
module sml_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] level_mv,
   input wire logic signal_absent_flag,
   input wire logic unlocked_indicator,
   input wire logic digital_loop_enable,
   input wire logic acquire_restart,
   input wire logic level_detector_powerdown,
   input wire logic [7:0] loss_threshold_mv,
   input wire logic [2:0] recovery_mode_select,
   input wire logic reference_assisted_acquisition
);
   logic [7:0] ctl;
   logic pin_sel;
   logic ld_q;
   wire logic wr_ctl = reg_wr && reg_addr == 8'h74;
   wire logic wr_cb = reg_wr && reg_addr == 8'h09;
   wire logic ld_now = wr_ctl && ctl[4] && !reg_wdata[4] && ctl[2:0] == 3'h1 && reg_wdata[2:0] == 3'h1;
   // shadows of the control byte and pin select, seen from the write port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) {ctl, pin_sel, ld_q} <= 10'h000;
      else {ctl, pin_sel, ld_q} <= {wr_ctl ? reg_wdata : ctl, wr_cb ? reg_wdata[4] : pin_sel, ld_now};
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_absent_set_low: assert property (
      !level_detector_powerdown && level_mv < loss_threshold_mv |=> signal_absent_flag)
      else $error("absent flag not set below threshold");
   chk_absent_clear_high: assert property (
      !level_detector_powerdown && {1'b0, level_mv} >= {loss_threshold_mv, 1'b0} |=> !signal_absent_flag)
      else $error("absent flag not cleared at twice threshold");
   chk_powerdown_freeze: assert property (
      level_detector_powerdown |=> $stable(signal_absent_flag))
      else $error("absent flag moved in powerdown");
   chk_thr_range: assert property (
      loss_threshold_mv <= 8'h80 && (loss_threshold_mv <= 8'h3F || !loss_threshold_mv[0]))
      else $error("threshold out of range or odd above 63");
   chk_thr_hold: assert property (
      !ld_now && !ld_q |=> $stable(loss_threshold_mv))
      else $error("threshold changed without strobe fall");
   chk_unlock_pin_live: assert property (
      !pin_sel |-> unlocked_indicator != digital_loop_enable)
      else $error("unlocked pin not following live lock");
   chk_loss_restart: assert property (
      $fell(digital_loop_enable) |-> acquire_restart)
      else $error("lock lost without restart pulse");
   chk_ref_mode_sel: assert property (
      reference_assisted_acquisition == (recovery_mode_select == 3'h3))
      else $error("reference mode flag wrong");
endmodule
`default_nettype wire

// ---- sml_host.sv ----
// sml_host: behavioural host on the monitor's register port
// assumes: called from the bench by hierarchical task calls, one at a time
`default_nettype none
module sml_host (
   input wire logic clk,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_wr, reg_addr, reg_wdata} = 17'h00000;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      {reg_wr, reg_wdata} <= {1'b0, ~d}; // released data does not keep the last value
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      #1 d = reg_rdata;
   endtask
   task automatic load_thr(input logic [7:0] mv);
      wr(8'h74, 8'h21);
      wr(8'h36, mv);
      wr(8'h74, 8'h31);
      wr(8'h74, 8'h21);
   endtask
   task automatic measure(input logic [7:0] last);
      wr(8'h74, 8'h07);
      wr(8'h74, 8'h17);
      wr(8'h74, last);
   endtask
endmodule
`default_nettype wire

// ---- signal_and_lock_monitor_tb_top.sv ----
// signal_and_lock_monitor_tb_top: self-checking bench of sml_monitor
// assumes: sml_pkg, sml_monitor, sml_host and sml_chk compiled before it
`default_nettype none
module signal_and_lock_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IVL = 64;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr, absent, unl, dle, restart, pdn, eqa, tfl, raa, rbp, fac;
   logic osc = 1'b0, dat = 1'b0, rf = 1'b0;
   logic [7:0] addr, wdata, rdata, thr, rdv, cfg, sl, sl_v;
   logic [7:0] lvl_mv = 8'h00;
   logic [5:0] eqc;
   logic [2:0] rms;
   logic [1:0] rng;
   logic [3:0] div;
   int err_total = 0, checks = 0, seed = 32'h35eebd6c;
   int osc_per = 2, tgt_per = 2, ref_per = 2, cyc = 0, n_restart = 0;
   int thr_q[$] = '{0, 1, 63, 64, 65, 127, 128};
   logic [7:0] ra[5] = '{8'h0A, 8'h16, 8'h74, 8'h36, 8'h55};
   logic [7:0] re[5] = '{8'h05, 8'h40, 8'h00, 8'h00, 8'h00};
   sml_monitor #(.INTERVAL(IVL)) i_dut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .level_mv(lvl_mv), .osc_tick(osc), .data_tick(dat), .ref_tick(rf),
      .signal_absent_flag(absent), .unlocked_indicator(unl), .digital_loop_enable(dle), .acquire_restart(restart),
      .level_detector_powerdown(pdn), .loss_threshold_mv(thr), .eq_adaptive(eqa), .eq_manual_code(eqc),
      .term_float(tfl), .recovery_mode_select(rms), .reference_assisted_acquisition(raa),
      .reference_range_select(rng), .data_reference_divide(div), .reference_buffer_powerdown(rbp),
      .fast_acquire(fac), .slice_setting(sl));
   sml_host i_host (.clk(clk), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      osc <= (cyc % osc_per) == 0;
      dat <= (cyc % tgt_per) == 0;
      rf <= (cyc % ref_per) == 0;
      if (restart === 1'b1) n_restart <= n_restart + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic int rnd(int v);
      return (v > 63) ? (v & ~1) : v;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic lvl(int v);
      @(posedge clk);
      lvl_mv <= 8'(v);
      tick(2);
   endtask
   task automatic wait_dle(logic v);
      int n;
      n = 0;
      while (dle !== v && n < 8 * IVL) begin
         tick(1);
         n++;
      end
      chk({7'h00, dle}, {7'h00, v}, "loop enable");
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int r, base;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      chk({6'h00, unl, dle}, 8'h02, "reset lock state");
      foreach (ra[i]) begin
         i_host.rd(ra[i], rdv);
         chk(rdv, re[i], "reset value");
      end
      repeat (3) thr_q.push_back(($random(seed) & 32'h7FFF) % 129);
      foreach (thr_q[i]) begin
         r = rnd(thr_q[i]);
         i_host.load_thr(8'(thr_q[i]));
         tick(1);
         chk(thr, 8'(r), "threshold");
         sl_v = 8'($random(seed));
         i_host.wr(8'h15, sl_v);
         tick(1);
         chk(sl, sl_v, "slice setting");
         if (r > 0) begin
            lvl(r - 1);
            chk({7'h00, absent}, 8'h01, "absent set");
            lvl(2 * r - 1);
            chk({7'h00, absent}, 8'h01, "absent held");
         end
         if (r < 128) begin
            lvl(2 * r);
            chk({7'h00, absent}, 8'h00, "absent clear");
            lvl(r);
            chk({7'h00, absent}, 8'h00, "absent stays clear");
         end
      end
      i_host.load_thr(8'h28);
      lvl(100);
      i_host.wr(8'h09, 8'h08);
      lvl(5);
      chk({6'h00, pdn, absent}, 8'h02, "frozen in powerdown");
      i_host.wr(8'h09, 8'h00);
      tick(2);
      chk({7'h00, absent}, 8'h01, "detector back on");
      base = $random(seed) & 32'hFF;
      lvl(base);
      i_host.measure(8'h07);
      i_host.rd(8'h36, rdv);
      chk(rdv, 8'(base), "measured level");
      lvl(base ^ 8'h5A);
      i_host.measure(8'h06);
      i_host.wr(8'h74, 8'h07);
      i_host.rd(8'h36, rdv);
      chk(rdv, 8'(base), "no measure load");
      i_host.wr(8'h16, 8'h8A);
      tick(1);
      chk({tfl, eqa, eqc}, 8'h8A, "eq manual float");
      i_host.wr(8'h16, 8'h4F);
      tick(1);
      chk({tfl, eqa, eqc}, 8'h4F, "eq adaptive tied");
      wait_dle(1);
      r = n_restart;
      osc_per = 3;
      wait_dle(0);
      tick(1);
      chk(8'(n_restart - r), 8'h01, "restart pulse");
      i_host.rd(8'h06, rdv);
      chk(rdv & 8'h06, 8'h06, "sticky and live");
      osc_per = 2;
      wait_dle(1);
      i_host.wr(8'h09, 8'h10);
      tick(1);
      chk({7'h00, unl}, 8'h01, "pin shows sticky");
      i_host.wr(8'h08, 8'h04);
      i_host.wr(8'h08, 8'h00);
      tick(1);
      chk({7'h00, unl}, 8'h00, "sticky cleared");
      i_host.wr(8'h09, 8'h00);
      cfg = 8'($random(seed)) & 8'h3F;
      i_host.wr(8'h0F, cfg);
      i_host.wr(8'h0A, 8'h01);
      r = n_restart;
      i_host.wr(8'h08, 8'h30);
      tick(2);
      tgt_per = 3;
      chk({2'b00, rms, raa, rbp, fac}, 8'h1D, "ref mode setup");
      chk({2'b00, rng, div}, {2'b00, cfg[5:0]}, "ref range divide");
      chk(8'(n_restart - r), 8'h01, "mode restart");
      i_host.rd(8'h06, rdv);
      chk(rdv & 8'h06, 8'h02, "mode change not sticky");
      wait_dle(1);
      ref_per = 3;
      wait_dle(0);
      test_done;
   end
endmodule
bind sml_monitor sml_chk i_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .level_mv(level_mv), .signal_absent_flag(signal_absent_flag), .unlocked_indicator(unlocked_indicator),
   .digital_loop_enable(digital_loop_enable), .acquire_restart(acquire_restart),
   .level_detector_powerdown(level_detector_powerdown), .loss_threshold_mv(loss_threshold_mv),
   .recovery_mode_select(recovery_mode_select), .reference_assisted_acquisition(reference_assisted_acquisition));
`default_nettype wire
